//--- core/xor_chain_defines.svh
`ifndef XOR_CHAIN_DEFINES_SVH
`define XOR_CHAIN_DEFINES_SVH

// ***********************
// Chain geometry
// ***********************
`define NUM_CHAINS       15
`define DATA_CHAIN_W     64
`define ADDR_CHAIN_W     40
`define MISC_CHAIN_W     64
`define NUM_LANES        16
`define NUM_MISC         12

// ***********************
// Chain index of each strap pin
// ***********************
`define IDX_ALL_HIGH_Z   0
`define IDX_XOR_TEST     1
`define IDX_SPEED_MID    6
`define IDX_SPEED_HIGH   7
`define IDX_LANE_REV     10
`define IDX_RESERVED_L18 11
`define IDX_SPEED_LOW    12
`define IDX_LANE_CHAIN   14

// ***********************
// Strap levels and reset values
// ***********************
`define XOR_STRAP_ACTIVE   1'b0
`define SPEED_LOW_REQUIRED 1'b1
`define RESULT_RESET       15'h0000
`define OE_RESET           15'h0000

`endif

//--- core/xor_chain_pkg.sv
package xor_chain_pkg;
  typedef enum logic [1:0] {BOOT_WAIT, FUNCTIONAL, XOR_TEST} boot_state_t;
  typedef logic [14:0] chain_vec_t;
endpackage : xor_chain_pkg

//--- core/boot_strap_if.sv
`timescale 1ns/10ps
interface boot_strap_if;
  logic xor_mode;
  logic lane_rev;
  logic full_width;
  modport ctrl (output xor_mode, output lane_rev, output full_width);
  modport user (input xor_mode, input lane_rev, input full_width);
endinterface : boot_strap_if

//--- core/strap_boot_ctrl.sv
`timescale 1ns/10ps
`include "xor_chain_defines.svh"
module strap_boot_ctrl
  import xor_chain_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic power_good_input,
  input  wire logic xor_test_strap,
  input  wire logic bus_speed_select_low_strap,
  input  wire logic lane_reversal_strap,
  input  wire logic reserved_l18_strap,
  boot_strap_if.ctrl bs
);
  boot_state_t state_ff, nxt_state;
  logic        rev_ff, nxt_rev;
  logic        full_ff, nxt_full;

  // ***********************
  // Boot sequencing
  // ***********************
  always_comb begin
    nxt_state = state_ff;
    nxt_rev   = rev_ff;
    nxt_full  = full_ff;
    unique case (state_ff)
      BOOT_WAIT: begin
        // Straps are taken once, on the edge that sees power good
        if (power_good_input) begin
          nxt_rev  = lane_reversal_strap;
          nxt_full = reserved_l18_strap;
          if (xor_test_strap == `XOR_STRAP_ACTIVE &&
              bus_speed_select_low_strap == `SPEED_LOW_REQUIRED) begin
            nxt_state = XOR_TEST;
          end else begin
            nxt_state = FUNCTIONAL;
          end
        end
      end
      FUNCTIONAL, XOR_TEST: begin
        // Straps are not looked at again until power good drops
        if (!power_good_input) begin
          nxt_state = BOOT_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= BOOT_WAIT;
      rev_ff   <= 1'b0;
      full_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rev_ff   <= nxt_rev;
      full_ff  <= nxt_full;
    end
  end

  assign bs.xor_mode   = (state_ff == XOR_TEST);
  assign bs.lane_rev   = rev_ff;
  assign bs.full_width = full_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  strap_entry_a: assert property (
    (state_ff == BOOT_WAIT && power_good_input && !xor_test_strap &&
     bus_speed_select_low_strap) |=> bs.xor_mode)
    else $error("xor mode not entered from straps");

  strap_hold_a: assert property (
    (bs.xor_mode && power_good_input) |=>
      (bs.xor_mode && $stable(rev_ff) && $stable(full_ff)))
    else $error("straps resampled while in xor mode");
endmodule : strap_boot_ctrl

//--- core/xor_chain_board_test.sv
`timescale 1ns/10ps
`include "xor_chain_defines.svh"
// Function
// - XOR mode is entered at boot from sampled straps, never by register.
// - Each chain output is the XNOR-style parity: all-high gives 1 if even.
// - Lowering one input of a chain flips that chain's output.
// - Fifteen chains, each on its own pair of output pins, some shared with straps.
// - Each chain result appears on both of its assigned output pins.
// - Chain 14 lanes: all when reserved strap high, else half by reversal.
// - Chain 0 folds the 64 host data pins and drives the high-z test pin.
// - Chain 1 folds 40 address, request, strobe pins onto xor test pin.
module xor_chain_board_test
  import xor_chain_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  input  wire logic                          power_good_input,
  input  wire logic                          xor_test_strap,
  input  wire logic [2:0]                    bus_speed_select_straps,
  input  wire logic                          lane_reversal_strap,
  input  wire logic                          reserved_l18_strap,
  input  wire logic [63:0]                   host_data_bus,
  input  wire logic [35:3]                   host_address_bus,
  input  wire logic [4:0]                    host_request_lines,
  input  wire logic [1:0]                    host_address_strobe,
  input  wire logic [15:0]                   graphics_lane_receive_pos,
  input  wire logic [15:0]                   graphics_lane_receive_neg,
  input  wire logic [15:0]                   graphics_lane_transmit_pos,
  input  wire logic [15:0]                   graphics_lane_transmit_neg,
  input  wire logic [`NUM_MISC-1:0][`MISC_CHAIN_W-1:0] misc_chain_pins,
  output logic [14:0]                        chain_result_pin,
  output logic [14:0]                        chain_result_dup_pin,
  output logic [14:0]                        chain_result_oe
);
  // ***********************
  // Walk order of the two tabulated chains
  // ***********************
  localparam int unsigned ORDER0 [64] = '{
    56, 52, 55, 57, 51, 58, 49, 62, 54, 50, 53, 59, 63, 61, 48, 60,
    26, 18, 17, 16, 25, 22, 20, 23, 19, 29, 27, 28, 30, 24, 31, 21,
    44, 45, 47, 40, 46, 32, 36, 38, 42, 34, 39, 41, 35, 37, 33, 43,
    15, 14, 11, 13,  9,  8, 12,  7,  5,  3,  6, 10,  0,  1,  4,  2};
  // Vector index: addr 3..35 -> 0..32, request 33..37, strobe 38..39
  localparam int unsigned ORDER1 [64] = '{
    37, 12, 34, 36,  0,  2,  3,  1,  4, 33, 38,  6, 35,  5,  8, 10,
    13,  9, 11,  7, 16, 18, 14, 22, 27, 17, 23, 24, 19, 39, 28, 15,
    31, 29, 20, 26, 21, 30, 25, 32,  0,  0,  0,  0,  0,  0,  0,  0,
     0,  0,  0,  0,  0,  0,  0,  0,  0,  0,  0,  0,  0,  0,  0,  0};

  // Folds pins in walk order, starting from 1 so all-high even reads 1
  function automatic logic chain_fold(input logic [63:0] pins,
                                      input int unsigned order [64],
                                      input int unsigned count);
    logic acc;
    acc = 1'b1;
    for (int i = 0; i < 64; i++) begin
      if (i < count) begin
        acc = acc ^ ~pins[order[i]];
      end
    end
    return acc;
  endfunction : chain_fold

  // Plain parity of a vector, same polarity as chain_fold
  function automatic logic chain_parity(input logic [63:0] pins);
    return ~^pins;
  endfunction : chain_parity

  // ***********************
  // Boot strap capture
  // ***********************
  boot_strap_if bs ();

  strap_boot_ctrl u_boot (
    .clk_sys                    (clk_sys),
    .resetn                     (resetn),
    .power_good_input           (power_good_input),
    .xor_test_strap             (xor_test_strap),
    .bus_speed_select_low_strap (bus_speed_select_straps[0]),
    .lane_reversal_strap        (lane_reversal_strap),
    .reserved_l18_strap         (reserved_l18_strap),
    .bs                         (bs.ctrl)
  );

  // ***********************
  // Chain trees
  // ***********************
  logic [63:0] addr_vec;
  logic [15:0] lane_mask;
  logic [15:0] lane_bits;
  chain_vec_t  parity;
  chain_vec_t  res_ff, nxt_res;
  chain_vec_t  oe_ff, nxt_oe;

  // Even count of inputs means an all-ones fold of 1 ^ 0 ^ ... stays 1
  always_comb begin
    addr_vec  = {24'h000000, host_address_strobe, host_request_lines,
                 host_address_bus};
    lane_bits = graphics_lane_receive_pos ^ graphics_lane_receive_neg ^
                graphics_lane_transmit_pos ^ graphics_lane_transmit_neg;
    if (bs.full_width) begin
      lane_mask = 16'hffff;
    end else if (bs.lane_rev) begin
      lane_mask = 16'h00ff;
    end else begin
      lane_mask = 16'hff00;
    end
    parity = '0;
    parity[`IDX_ALL_HIGH_Z] = chain_fold(host_data_bus, ORDER0,
                                          `DATA_CHAIN_W);
    parity[`IDX_XOR_TEST]   = chain_fold(addr_vec, ORDER1,
                                          `ADDR_CHAIN_W);
    for (int c = 2; c < `IDX_LANE_CHAIN; c++) begin
      parity[c] = chain_parity(misc_chain_pins[c-2]);
    end
    // Four pins per lane keep the count even, so masking keeps polarity
    parity[`IDX_LANE_CHAIN] =
      chain_parity({48'h000000000000, lane_bits & lane_mask});
  end

  // ***********************
  // Output registers
  // ***********************
  always_comb begin
    nxt_res = `RESULT_RESET;
    nxt_oe  = `OE_RESET;
    if (bs.xor_mode) begin
      nxt_res = parity;
      nxt_oe  = '1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      res_ff <= `RESULT_RESET;
      oe_ff  <= `OE_RESET;
    end else begin
      res_ff <= nxt_res;
      oe_ff  <= nxt_oe;
    end
  end

  assign chain_result_pin     = res_ff;
  assign chain_result_dup_pin = res_ff;
  assign chain_result_oe      = oe_ff;

  // ***********************
  // Checks
  // ***********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence steady_mode_s;
    bs.xor_mode && $past(bs.xor_mode);
  endsequence

  sequence one_data_step_s;
    $countones(host_data_bus ^ $past(host_data_bus)) == 1;
  endsequence

  sequence one_addr_step_s;
    $countones(addr_vec ^ $past(addr_vec)) == 1;
  endsequence

  data_high_even_a: assert property (
    (bs.xor_mode && (&host_data_bus)) |=> chain_result_pin[0] == 1'b1)
    else $error("chain 0 all-high level wrong");

  addr_high_even_a: assert property (
    (bs.xor_mode && (&host_address_bus) && (&host_request_lines) &&
     (&host_address_strobe)) |=> chain_result_pin[1] == 1'b1)
    else $error("chain 1 all-high level wrong");

  data_step_flip_a: assert property (
    (steady_mode_s and one_data_step_s) |=>
      chain_result_pin[0] != $past(chain_result_pin[0]))
    else $error("chain 0 did not toggle on single pin step");

  data_fold_a: assert property (
    bs.xor_mode |=> chain_result_pin[0] == ~^$past(host_data_bus))
    else $error("chain 0 result differs from data parity");

  dup_pin_match_a: assert property (
    (chain_result_dup_pin == chain_result_pin) and
    (bs.xor_mode |=> chain_result_dup_pin[1] == ~^$past(addr_vec)))
    else $error("duplicate chain pin differs");

  addr_step_flip_a: assert property (
    (steady_mode_s and one_addr_step_s) |=>
      chain_result_pin[1] != $past(chain_result_pin[1]))
    else $error("chain 1 did not toggle on single pin step");

  addr_fold_a: assert property (
    bs.xor_mode |=> chain_result_pin[1] == ~^$past(addr_vec))
    else $error("chain 1 result differs from address parity");

  misc_fold_a: assert property (
    bs.xor_mode |=> (chain_result_pin[2] == ~^$past(misc_chain_pins[0]) &&
                     chain_result_pin[13] == ~^$past(misc_chain_pins[11])))
    else $error("chain 2 or 13 result differs from pin parity");

  lane_full_a: assert property (
    (bs.xor_mode && bs.full_width) |=>
      chain_result_pin[14] == ~^$past(lane_bits))
    else $error("chain 14 full width selection wrong");

  lane_low_a: assert property (
    (bs.xor_mode && !bs.full_width && bs.lane_rev) |=>
      chain_result_pin[14] == ~^$past(lane_bits[7:0]))
    else $error("chain 14 reversed lane selection wrong");

  lane_half_a: assert property (
    (bs.xor_mode && !bs.full_width && !bs.lane_rev) |=>
      chain_result_pin[14] == ~^$past(lane_bits[15:8]))
    else $error("chain 14 lane selection wrong");

  strap_drive_a: assert property (
    bs.xor_mode |=> chain_result_oe == 15'h7fff)
    else $error("strap pins not driven in xor mode");

  idle_quiet_a: assert property (
    !bs.xor_mode |=> (chain_result_oe == 15'h0000 &&
                      chain_result_pin == 15'h0000))
    else $error("chain pins active outside xor mode");
endmodule : xor_chain_board_test

//--- tb/ate_model.sv
`timescale 1ns/10ps
// ***********************
// Tester side: boot straps and power good
// ***********************
module ate_model (
  input  wire logic       clk_sys,
  output logic            power_good_input,
  output logic            xor_test_strap,
  output logic [2:0]      bus_speed_select_straps,
  output logic            lane_reversal_strap,
  output logic            reserved_l18_strap
);
  initial begin
    power_good_input        = 1'b0;
    xor_test_strap          = 1'b1;
    bus_speed_select_straps = 3'h1;
    lane_reversal_strap     = 1'b0;
    reserved_l18_strap      = 1'b0;
  end

  task automatic boot(input logic xt, input logic [2:0] bs,
                      input logic rv, input logic rs);
    @(posedge clk_sys);
    power_good_input <= 1'b0;
    repeat (2) @(posedge clk_sys);
    xor_test_strap          <= xt;
    bus_speed_select_straps <= bs;
    lane_reversal_strap     <= rv;
    reserved_l18_strap      <= rs;
    repeat (2) @(posedge clk_sys);
    power_good_input <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // Pins now carry results, so the boot levels are no longer held
    xor_test_strap          <= ~xt;
    bus_speed_select_straps <= ~bs;
    lane_reversal_strap     <= ~rv;
    reserved_l18_strap      <= ~rs;
  endtask : boot
endmodule : ate_model

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import xor_chain_pkg::*;
  localparam int NB = 936;
  logic            clk_sys;
  logic            resetn;
  logic            pg;
  logic            xt;
  logic            rv;
  logic            rs;
  logic [2:0]      bs;
  logic [NB-1:0]   flat;
  chain_vec_t      pin;
  chain_vec_t      dup;
  chain_vec_t      oe;
  logic            xm;
  logic            rv_c;
  logic            rs_c;
  logic [5:0]      cfg [5];
  int              miscompares;
  int              checks_done;

  ate_model ate_model_inst (.clk_sys(clk_sys), .power_good_input(pg),
    .xor_test_strap(xt), .bus_speed_select_straps(bs),
    .lane_reversal_strap(rv), .reserved_l18_strap(rs));

  xor_chain_board_test xor_chain_board_test_inst (.clk_sys(clk_sys),
    .resetn(resetn), .power_good_input(pg), .xor_test_strap(xt),
    .bus_speed_select_straps(bs), .lane_reversal_strap(rv),
    .reserved_l18_strap(rs), .host_data_bus(flat[63:0]),
    .host_address_bus(flat[103:71]), .host_request_lines(flat[70:66]),
    .host_address_strobe(flat[65:64]), .misc_chain_pins(flat[871:104]),
    .graphics_lane_receive_pos(flat[887:872]),
    .graphics_lane_receive_neg(flat[903:888]),
    .graphics_lane_transmit_pos(flat[919:904]),
    .graphics_lane_transmit_neg(flat[935:920]),
    .chain_result_pin(pin), .chain_result_dup_pin(dup),
    .chain_result_oe(oe));

  // ***********************
  // Expected results and checking
  // ***********************
  function automatic chain_vec_t expect_out();
    chain_vec_t  e;
    logic [15:0] m;
    m = rs_c ? 16'hffff : (rv_c ? 16'h00ff : 16'hff00);
    e[0] = 1'b1 ^ (^flat[63:0]);
    e[1] = 1'b1 ^ (^flat[103:64]);
    for (int c = 2; c < 14; c++) begin
      e[c] = 1'b1 ^ (^flat[104+64*(c-2) +: 64]);
    end
    e[14] = 1'b1 ^ (^((flat[887:872] ^ flat[903:888] ^ flat[919:904]
                     ^ flat[935:920]) & m));
    return xm ? e : 15'h0000;
  endfunction : expect_out

  task automatic check(input string nm, input chain_vec_t seen,
                       input chain_vec_t exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
    check("chain_result_pin", pin, expect_out());
    check("chain_result_dup_pin", dup, expect_out());
    check("chain_result_oe", oe, xm ? 15'h7fff : 15'h0000);
  endtask : settle

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // ***********************
  // Stimulus
  // ***********************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    #1ms;
    miscompares++;
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    flat = '1;
    xm = 1'b0;
    rv_c = 1'b0;
    rs_c = 1'b0;
    miscompares = 0;
    checks_done = 0;
    cfg = '{6'b1_001_0_0, 6'b0_000_0_1, 6'b0_111_0_1, 6'b0_011_0_0,
            6'b0_101_1_0};
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      flat <= '1;
      ate_model_inst.boot(cfg[k][5], cfg[k][4:2], cfg[k][1], cfg[k][0]);
      xm = ~cfg[k][5] & cfg[k][2];
      rv_c = cfg[k][1];
      rs_c = cfg[k][0];
      settle();
      // Walk one low through every chain input, lanes outside chain 14 too
      for (int i = 0; i < NB; i++) begin
        @(posedge clk_sys);
        flat <= ~(NB'(1) << i);
        settle();
      end
      $display("test %0d done", k);
    end
    // Reset in mid-run drops xor mode; the pins now read functional straps
    @(posedge clk_sys);
    resetn <= 1'b0;
    xm = 1'b0;
    settle();
    @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    $display("test 5 done");
    end_sim();
  end
endmodule : testbench
